// ### design/cci_pkg.sv
// Package with constants and types shared by the counter interrupt unit.
package cci_pkg;

    localparam int unsigned CLK_HZ     = 25_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

    // Measuring intervals in milliseconds and their cycle counts.
    localparam int unsigned MEAS_SHORT_MS = 10;
    localparam int unsigned MEAS_MID_MS   = 100;
    localparam int unsigned MEAS_LONG_MS  = 1000;
    localparam int unsigned MEAS_SHORT_CYC = MEAS_SHORT_MS * CYC_PER_MS;
    localparam int unsigned MEAS_MID_CYC   = MEAS_MID_MS * CYC_PER_MS;
    localparam int unsigned MEAS_LONG_CYC  = MEAS_LONG_MS * CYC_PER_MS;

    // Pulses per interval times this factor give hertz.
    localparam logic [31:0] SCALE_SHORT = 32'h0000_0064;
    localparam logic [31:0] SCALE_MID   = 32'h0000_000A;
    localparam logic [31:0] SCALE_LONG  = 32'h0000_0001;

    // Longest allowed response time and the same limit in clock cycles.
    localparam int unsigned RESP_TIME_US = 1000;
    localparam int unsigned RESP_CYC     = RESP_TIME_US * (CLK_HZ / 1_000_000);

    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_SETPOINT = 4'h4;
    localparam logic [3:0] OFS_COUNT    = 4'h8;
    localparam logic [3:0] OFS_BITS     = 4'hC;

    localparam logic [31:0] CNT_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] CNT_MIN = 32'h8000_0000;

    typedef enum logic [2:0] {
        MODE_EXT_DIR = 3'b000,
        MODE_DUAL    = 3'b001,
        MODE_QUAD    = 3'b010,
        MODE_F_OVER  = 3'b011,
        MODE_F_UNDER = 3'b100
    } cci_mode_t;

    typedef enum logic [1:0] {
        IVL_SHORT = 2'b00,
        IVL_MID   = 2'b01,
        IVL_LONG  = 2'b10
    } cci_ivl_t;

    // Control register layout, msb first: bits 16..0.
    typedef struct packed {
        logic      enRelease;
        logic      enable;
        logic      countClear;
        logic [2:0] rsvd;
        cci_mode_t mode;
        cci_ivl_t  interval;
        logic [2:0] selA;
        logic [2:0] selB;
    } cci_ctrl_t;

    localparam cci_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 3'h0, MODE_EXT_DIR,
                                         IVL_SHORT, 3'h0, 3'h4};

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] rise;
        logic [7:0] fall;
    } cci_edges_t;

endpackage : cci_pkg

// ### design/cci_edge_sync.sv
// Input synchroniser and edge detector for the eight device pulse inputs.
`timescale 1ns/1ps
module cci_edge_sync
    import cci_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic [7:0] devicePulseInputs,
    output cci_edges_t      edges
);
    logic [7:0] meta_ff;
    logic [7:0] sync_ff;
    logic [7:0] last_ff;

    // The first stage feeds only the second stage; edges compare stages two and three.
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (srst)
                begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                    last_ff[i] <= 1'b0;
                end
                else
                begin
                    meta_ff[i] <= devicePulseInputs[i];
                    sync_ff[i] <= meta_ff[i];
                    last_ff[i] <= sync_ff[i];
                end
            end
            assign edges.level[i] = sync_ff[i];
            assign edges.rise[i]  = sync_ff[i] & ~last_ff[i];
            assign edges.fall[i]  = ~sync_ff[i] & last_ff[i];
        end
    endgenerate

endmodule : cci_edge_sync

// ### design/cci_freq_meter.sv
// Gate-time frequency meter: counts pulses per interval and reports hertz.
`timescale 1ns/1ps
module cci_freq_meter
    import cci_pkg::*;
#(
    parameter int unsigned SHORT_CYC = MEAS_SHORT_CYC,
    parameter int unsigned MID_CYC   = MEAS_MID_CYC,
    parameter int unsigned LONG_CYC  = MEAS_LONG_CYC
)
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        run,
    input  wire logic        pulse,
    input  cci_ivl_t         interval,
    output logic             freqValid,
    output logic [31:0]      freqHz
);
    logic [31:0] gate_ff;
    logic [31:0] pulses_ff;
    logic [31:0] gateLen;
    logic [31:0] scale;
    logic        gateEnd;

    always_comb
    begin
        case (interval)
            IVL_SHORT:
            begin
                gateLen = 32'(SHORT_CYC);
                scale   = SCALE_SHORT;
            end
            IVL_MID:
            begin
                gateLen = 32'(MID_CYC);
                scale   = SCALE_MID;
            end
            default:
            begin
                gateLen = 32'(LONG_CYC);
                scale   = SCALE_LONG;
            end
        endcase
    end

    assign gateEnd = run && (gate_ff >= gateLen - 32'h0000_0001);

    always_ff @(posedge core_clk)
    begin
        if (srst || !run || gateEnd)
            gate_ff <= 32'h0000_0000;
        else
            gate_ff <= gate_ff + 32'h0000_0001;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst || !run || gateEnd)
            pulses_ff <= 32'h0000_0000;
        else if (pulse && pulses_ff != 32'hFFFF_FFFF)
            pulses_ff <= pulses_ff + 32'h0000_0001;
    end

    // A pulse landing on the closing cycle belongs to the closed interval.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            freqValid <= 1'b0;
            freqHz    <= 32'h0000_0000;
        end
        else
        begin
            freqValid <= gateEnd;
            if (gateEnd)
                freqHz <= 32'((pulses_ff + 32'(pulse)) * scale);
        end
    end

endmodule : cci_freq_meter

// ### design/cci_counter_unit.sv
// Counter and frequency triggered interrupt unit with an AHB-Lite register slave.
//
// Summary of operation
// - Block runs only while enable is 1 when the enable-release option is on.
// - Count clear at 1 forces the counter to zero.
// - Four main-program bits are copied out for the interrupt routine.
// - Direction mode: pulse steps count, direction 0 counts up, 1 down, up to 5kHz.
// - Dual mode: first input pulses count up, second input pulses count down.
// - Quadrature mode takes channels A and B and finds direction from phase.
// - Quadrature: each full A and B period changes the count by two.
// - Over-frequency mode triggers when measured frequency exceeds the setpoint.
// - Under-frequency mode triggers when measured frequency falls below the setpoint.
// - Measuring intervals of 0.01 s, 0.1 s and 1.0 s are selectable.
// - Four result bits set by the routine are readable by the main program.
// - Counting modes request an interrupt when the count reaches the setpoint.
// - Trigger to output response stays below one millisecond.
// - Triggers are ignored while this unit's routine is running.
// - With the option off, the block is always enabled and ignores enable.
`timescale 1ns/1ps
module cci_counter_unit
    import cci_pkg::*;
#(
    parameter int unsigned SHORT_CYC = MEAS_SHORT_CYC,
    parameter int unsigned MID_CYC   = MEAS_MID_CYC,
    parameter int unsigned LONG_CYC  = MEAS_LONG_CYC
)
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  devicePulseInputs,
    input  wire logic        routineBusy,
    input  wire logic [3:0]  routineResultBits,
    output logic [3:0]       routineMainBits,
    output logic [3:0]       resultBitsOut,
    output logic [31:0]      countOutput,
    output logic             irqReq
);
    cci_ctrl_t   ctrl_ff;
    logic [31:0] setpoint_ff;
    logic [31:0] count_ff;
    logic [31:0] nxt_count;
    logic [3:0]  mainBits_ff;
    logic [3:0]  result_ff;
    logic        pend_ff;
    logic        wrPend_ff;
    logic [3:0]  addr_ff;
    logic        rdPend_ff;
    cci_edges_t  edges;
    logic        freqValid;
    logic [31:0] freqHz;
    logic        active;
    logic        stepUp;
    logic        stepDn;
    logic        trig;
    logic        accept;
    logic        freqMode;
    logic        bLvl;
    logic        aRise;
    logic        bRise;
    logic        aFall;

    cci_edge_sync u_sync (
        .core_clk          (core_clk),
        .srst              (srst),
        .devicePulseInputs (devicePulseInputs),
        .edges             (edges)
    );

    cci_freq_meter #(
        .SHORT_CYC (SHORT_CYC),
        .MID_CYC   (MID_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_meter (
        .core_clk  (core_clk),
        .srst      (srst),
        .run       (active && freqMode),
        .pulse     (aRise),
        .interval  (ctrl_ff.interval),
        .freqValid (freqValid),
        .freqHz    (freqHz)
    );

    // Bus slave: every transfer completes with no wait state and an OKAY answer.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wrPend_ff <= 1'b0;
            rdPend_ff <= 1'b0;
            addr_ff   <= 4'h0;
        end
        else if (hready)
        begin
            wrPend_ff <= hsel && htrans[1] && hwrite;
            rdPend_ff <= hsel && htrans[1] && !hwrite;
            addr_ff   <= {haddr[3:2], 2'b00};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ctrl_ff     <= CTRL_RESET;
            setpoint_ff <= 32'h0000_0000;
            mainBits_ff <= 4'h0;
        end
        else if (wrPend_ff)
        begin
            case (addr_ff)
                OFS_CTRL:     ctrl_ff     <= cci_ctrl_t'(hwdata[16:0]);
                OFS_SETPOINT: setpoint_ff <= hwdata;
                OFS_BITS:     mainBits_ff <= hwdata[3:0];
                default:      ;
            endcase
        end
    end

    // Read data is a mux of flip-flops so a write is visible to the very next read.
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (rdPend_ff)
        begin
            case (addr_ff)
                OFS_CTRL:     hrdata = {15'h0000, ctrl_ff};
                OFS_SETPOINT: hrdata = setpoint_ff;
                OFS_COUNT:    hrdata = count_ff;
                OFS_BITS:     hrdata = {15'h0000, pend_ff, 4'h0, result_ff, 4'h0, mainBits_ff};
                default:      hrdata = 32'h0000_0000;
            endcase
        end
    end

    assign routineMainBits = mainBits_ff;
    assign resultBitsOut   = result_ff;
    assign countOutput     = count_ff;
    assign irqReq          = pend_ff;

    // The routine's outputs are latched only while it runs, then held for the main program.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            result_ff <= 4'h0;
        else if (routineBusy)
            result_ff <= routineResultBits;
    end

    assign active = !ctrl_ff.enRelease || ctrl_ff.enable;
    assign bLvl   = edges.level[ctrl_ff.selB];
    assign aRise  = edges.rise[ctrl_ff.selA];
    assign aFall  = edges.fall[ctrl_ff.selA];
    assign bRise  = edges.rise[ctrl_ff.selB];
    assign freqMode = (ctrl_ff.mode == MODE_F_OVER) || (ctrl_ff.mode == MODE_F_UNDER);

    always_comb
    begin
        stepUp = 1'b0;
        stepDn = 1'b0;
        case (ctrl_ff.mode)
            MODE_EXT_DIR:
            begin
                stepUp = aRise && !bLvl;
                stepDn = aRise && bLvl;
            end
            MODE_DUAL:
            begin
                stepUp = aRise && !bRise;
                stepDn = bRise && !aRise;
            end
            MODE_QUAD:
            begin
                // Both A edges count, so a full period moves the count by two.
                stepUp = (aRise && !bLvl) || (aFall && bLvl);
                stepDn = (aRise && bLvl) || (aFall && !bLvl);
            end
            default:
            begin
                stepUp = 1'b0;
                stepDn = 1'b0;
            end
        endcase
        if (!active)
        begin
            stepUp = 1'b0;
            stepDn = 1'b0;
        end
    end

    always_comb
    begin
        nxt_count = count_ff;
        if (ctrl_ff.countClear)
            nxt_count = 32'h0000_0000;
        else if (stepUp && count_ff != CNT_MAX)
            nxt_count = count_ff + 32'h0000_0001;
        else if (stepDn && count_ff != CNT_MIN)
            nxt_count = count_ff - 32'h0000_0001;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            count_ff <= 32'h0000_0000;
        else
            count_ff <= nxt_count;
    end

    always_comb
    begin
        case (ctrl_ff.mode)
            MODE_F_OVER:  trig = freqValid && ($signed(freqHz) > $signed(setpoint_ff));
            MODE_F_UNDER: trig = freqValid && ($signed(freqHz) < $signed(setpoint_ff));
            default:      trig = (stepUp || stepDn) && !ctrl_ff.countClear
                                 && (nxt_count == setpoint_ff);
        endcase
    end

    assign accept = active && trig && !routineBusy;

    // The request stands until the routine starts; a trigger in that same cycle is masked by routineBusy, so the clear wins.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            pend_ff <= 1'b0;
        else if (accept)
            pend_ff <= 1'b1;
        else if (routineBusy)
            pend_ff <= 1'b0;
    end

    a_clear_zero: assert property (@(posedge core_clk) disable iff (srst)
        ctrl_ff.countClear |=> count_ff == 32'h0000_0000)
        else $error("count not zero after clear");

    a_disabled_hold: assert property (@(posedge core_clk) disable iff (srst)
        (ctrl_ff.enRelease && !ctrl_ff.enable && !ctrl_ff.countClear)
        |=> count_ff == $past(count_ff))
        else $error("count moved while disabled");

    a_dir_up_opt: assert property (@(posedge core_clk) disable iff (srst)
        (!ctrl_ff.enRelease && ctrl_ff.mode == MODE_EXT_DIR && aRise && !bLvl
         && !ctrl_ff.countClear && count_ff != CNT_MAX)
        |=> count_ff == $past(count_ff) + 32'h0000_0001)
        else $error("direction up step missing with option off");

    a_dual_down: assert property (@(posedge core_clk) disable iff (srst)
        (active && ctrl_ff.mode == MODE_DUAL && bRise && !aRise
         && !ctrl_ff.countClear && count_ff != CNT_MIN)
        |=> count_ff == $past(count_ff) - 32'h0000_0001)
        else $error("dual down step missing");

    a_quad_fall: assert property (@(posedge core_clk) disable iff (srst)
        (active && ctrl_ff.mode == MODE_QUAD && aFall && bLvl
         && !ctrl_ff.countClear && count_ff != CNT_MAX)
        |=> count_ff == $past(count_ff) + 32'h0000_0001)
        else $error("quadrature falling edge not counted");

    a_sat_top: assert property (@(posedge core_clk) disable iff (srst)
        (count_ff == CNT_MAX && !ctrl_ff.countClear) |=> !$rose(count_ff[31]))
        else $error("count wrapped past maximum");

    a_reach_irq: assert property (@(posedge core_clk) disable iff (srst)
        (active && !routineBusy && !freqMode && (stepUp || stepDn)
         && !ctrl_ff.countClear && nxt_count == setpoint_ff)
        |=> irqReq && count_ff == setpoint_ff)
        else $error("setpoint reached without request");

    a_freq_over: assert property (@(posedge core_clk) disable iff (srst)
        (active && !routineBusy && ctrl_ff.mode == MODE_F_OVER && freqValid
         && $signed(freqHz) > $signed(setpoint_ff)) |=> irqReq)
        else $error("over-frequency not requested");

    a_freq_under: assert property (@(posedge core_clk) disable iff (srst)
        (active && !routineBusy && ctrl_ff.mode == MODE_F_UNDER && freqValid
         && $signed(freqHz) < $signed(setpoint_ff)) |=> irqReq)
        else $error("under-frequency not requested");

    a_busy_ignore: assert property (@(posedge core_clk) disable iff (srst)
        routineBusy |=> !irqReq)
        else $error("request raised while routine busy");

    a_accept_resp: assert property (@(posedge core_clk) disable iff (srst)
        accept |=> irqReq)
        else $error("accepted trigger produced no request");

    a_ext_down: assert property (@(posedge core_clk) disable iff (srst)
        (active && ctrl_ff.mode == MODE_EXT_DIR && aRise && bLvl
         && !ctrl_ff.countClear && count_ff != CNT_MIN)
        |=> count_ff == $past(count_ff) - 32'h0000_0001)
        else $error("direction down step missing");

    a_bits_latch: assert property (@(posedge core_clk) disable iff (srst)
        routineBusy |=> resultBitsOut == $past(routineResultBits))
        else $error("routine bits not latched while busy");

endmodule : cci_counter_unit

// ### tb/cci_field_src.sv
// Behavioural model of the field pulse sources wired to the device inputs.
`timescale 1ns/1ps
module cci_field_src
(
    input  wire logic       core_clk,
    output logic [7:0]      pins
);
    logic freqRun;
    int   freqIdx;
    int   phase;

    initial
    begin
        pins    = 8'h00;
        freqRun = 1'b0;
        freqIdx = 0;
        phase   = 0;
    end

    // Square wave of four cycles per period, so every level lasts two cycles.
    always @(posedge core_clk)
    begin
        if (freqRun)
        begin
            phase = phase + 1;
            if (phase % 2 == 0)
                pins[freqIdx] <= ~pins[freqIdx];
        end
    end

    task setPin(input int idx, input logic v);
        pins[idx] <= v;
    endtask : setPin

    // The width w lets a scenario play both a prompt and a slow source.
    task pulse(input int idx, input int w);
        pins[idx] <= 1'b1;
        repeat (w) @(posedge core_clk);
        pins[idx] <= 1'b0;
        repeat (w) @(posedge core_clk);
    endtask : pulse

    // One full period, levels given as {A, B}, channels a quarter period apart.
    task quad(input int a, input int b, input logic down, input int w);
        logic [1:0] seq [4];
        if (down)
            seq = '{2'b01, 2'b11, 2'b10, 2'b00};
        else
            seq = '{2'b10, 2'b11, 2'b01, 2'b00};
        for (int i = 0; i < 4; i++)
        begin
            pins[a] <= seq[i][1];
            pins[b] <= seq[i][0];
            repeat (w) @(posedge core_clk);
        end
    endtask : quad
endmodule : cci_field_src

// ### tb/cci_counter_unit_tb.sv
// Self-checking bench for the counter interrupt unit driven by the field source model.
`timescale 1ns/1ps
module cci_counter_unit_tb
    import cci_pkg::*;
;
    localparam int SC = 20;
    localparam int MC = 40;
    localparam int LC = 80;

    logic        core_clk;
    logic        srst;
    logic        hsel;
    logic        hwrite;
    logic        rdPhase;
    logic        routineBusy;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] countOutput;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout;
    logic        hresp;
    logic        irqReq;
    logic [3:0]  routineResultBits;
    logic [3:0]  routineMainBits;
    logic [3:0]  resultBitsOut;
    logic [3:0]  mb;
    logic [3:0]  rb;
    logic [7:0]  pins;
    logic [31:0] expQ [$];
    int          badCount;
    int          numChecks;
    int          seed;
    int          gate;
    int          sp;

    always #20 core_clk = ~core_clk;

    cci_counter_unit #(.SHORT_CYC(SC), .MID_CYC(MC), .LONG_CYC(LC)) u_dut (
        .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .devicePulseInputs(pins), .routineBusy(routineBusy),
        .routineResultBits(routineResultBits), .routineMainBits(routineMainBits),
        .resultBitsOut(resultBitsOut), .countOutput(countOutput), .irqReq(irqReq));

    cci_field_src u_src (.core_clk(core_clk), .pins(pins));

    task giveVerdict;
        if (badCount == 0 && numChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : giveVerdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task waitRdy;
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
            @(posedge core_clk);
    endtask : waitRdy

    task ahbAddr(input logic [31:0] a, input logic w);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        waitRdy();
        htrans <= 2'b00;
        hsel   <= 1'b0;
    endtask : ahbAddr

    task wr(input logic [31:0] a, input logic [31:0] d);
        ahbAddr(a, 1'b1);
        hwdata <= d;
        waitRdy();
    endtask : wr

    // The monitor below compares the read data at the closing edge of the data phase.
    task rd(input logic [31:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        ahbAddr(a, 1'b0);
        rdPhase <= 1'b1;
        waitRdy();
        rdPhase <= 1'b0;
    endtask : rd

    always @(posedge core_clk)
    begin
        if (rdPhase && hreadyout === 1'b1 && expQ.size() > 0)
        begin
            chk(hrdata, expQ.pop_front());
            chk({31'h0, hresp}, 32'h0);
        end
    end

    task ack;
        routineBusy <= 1'b1;
        repeat (2) @(posedge core_clk);
        routineBusy <= 1'b0;
        @(posedge core_clk);
    endtask : ack

    // Level requests stand until acknowledged, so a full-length watch is safe.
    task waitIrq(input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (n)
        begin
            @(posedge core_clk);
            if (irqReq === 1'b1)
                seen = 1'b1;
        end
        chk({31'h0, seen}, {31'h0, exp});
    endtask : waitIrq

    function automatic logic [31:0] ctl(input logic r, input logic e, input logic c,
        input cci_mode_t m, input cci_ivl_t v, input logic [2:0] a, input logic [2:0] b);
        cci_ctrl_t t;
        t = '{r, e, c, 3'h0, m, v, a, b};
        return {15'h0, t};
    endfunction : ctl

    initial
    begin
        repeat (20000) @(posedge core_clk);
        badCount++;
        giveVerdict();
    end

    initial
    begin
        core_clk = 1'b0; srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; rdPhase = 1'b0;
        routineBusy = 1'b0; routineResultBits = 4'h0; badCount = 0; numChecks = 0;
        seed = 59343;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rd(32'h0, {15'h0, CTRL_RESET});
        rd(32'h8, 32'h0);
        wr(32'h8, 32'h0000_1234);
        rd(32'h8, 32'h0);
        mb = 4'($random(seed));
        rb = 4'($random(seed));
        wr(32'hC, {28'h0, mb});
        @(posedge core_clk);
        chk({28'h0, routineMainBits}, {28'h0, mb});
        routineResultBits <= rb;
        ack();
        chk({28'h0, resultBitsOut}, {28'h0, rb});
        rd(32'hC, {20'h0, rb, 4'h0, mb});
        wr(32'h4, 32'h3);
        wr(32'h0, ctl(1'b0, 1'b0, 1'b0, MODE_EXT_DIR, IVL_SHORT, 3'h0, 3'h4));
        repeat (3) u_src.pulse(0, 3);
        @(posedge core_clk);
        rd(32'h8, 32'h3);
        chk({31'h0, irqReq}, 32'h1);
        ack();
        chk({31'h0, irqReq}, 32'h0);
        wr(32'h4, 32'h2);
        u_src.setPin(4, 1'b1);
        @(posedge core_clk);
        routineBusy <= 1'b1;
        repeat (2) u_src.pulse(0, 3);
        @(posedge core_clk);
        chk({31'h0, irqReq}, 32'h0);
        routineBusy <= 1'b0;
        rd(32'h8, 32'h1);
        u_src.setPin(4, 1'b0);
        wr(32'h0, ctl(1'b0, 1'b0, 1'b1, MODE_EXT_DIR, IVL_SHORT, 3'h0, 3'h4));
        u_src.pulse(0, 3);
        rd(32'h8, 32'h0);
        wr(32'h0, ctl(1'b1, 1'b0, 1'b0, MODE_DUAL, IVL_SHORT, 3'h0, 3'h1));
        u_src.pulse(0, 6);
        rd(32'h8, 32'h0);
        wr(32'h0, ctl(1'b1, 1'b1, 1'b0, MODE_DUAL, IVL_SHORT, 3'h0, 3'h1));
        u_src.pulse(0, 3);
        rd(32'h8, 32'h1);
        wr(32'h0, ctl(1'b0, 1'b0, 1'b0, MODE_DUAL, IVL_SHORT, 3'h0, 3'h1));
        u_src.pulse(0, 3);
        rd(32'h8, 32'h2);
        chk({31'h0, irqReq}, 32'h1);
        u_src.pulse(1, 3);
        rd(32'h8, 32'h1);
        chk(countOutput, 32'h1);
        ack();
        wr(32'h0, ctl(1'b0, 1'b0, 1'b1, MODE_QUAD, IVL_SHORT, 3'h2, 3'h3));
        wr(32'h4, 32'h4);
        wr(32'h0, ctl(1'b0, 1'b0, 1'b0, MODE_QUAD, IVL_SHORT, 3'h2, 3'h3));
        repeat (2) u_src.quad(2, 3, 1'b0, 3);
        @(posedge core_clk);
        chk({31'h0, irqReq}, 32'h1);
        rd(32'h8, 32'h4);
        ack();
        u_src.quad(2, 3, 1'b1, 3);
        rd(32'h8, 32'h2);
        // Setpoint is half the expected reading, so a wrong scale or gate shows.
        for (int i = 0; i < 3; i++)
        begin
            gate = (i == 0) ? SC : (i == 1) ? MC : LC;
            sp = (gate / 4) * ((i == 0) ? 100 : (i == 1) ? 10 : 1) / 2;
            u_src.freqIdx <= 5;
            u_src.freqRun <= 1'b1;
            wr(32'h4, sp);
            rd(32'h4, sp);
            wr(32'h0, ctl(1'b0, 1'b0, 1'b0, MODE_F_OVER, cci_ivl_t'(i), 3'h5, 3'h0));
            waitIrq(3 * gate + 10, 1'b1);
            // Parked disabled so the running source cannot step the count meanwhile.
            wr(32'h0, ctl(1'b1, 1'b0, 1'b0, MODE_DUAL, IVL_SHORT, 3'h5, 3'h0));
            ack();
            wr(32'h0, ctl(1'b0, 1'b0, 1'b0, MODE_F_UNDER, cci_ivl_t'(i), 3'h5, 3'h0));
            waitIrq(3 * gate, 1'b0);
            u_src.freqRun <= 1'b0;
            waitIrq(3 * gate + 10, 1'b1);
            wr(32'h0, ctl(1'b1, 1'b0, 1'b0, MODE_DUAL, IVL_SHORT, 3'h5, 3'h0));
            ack();
        end
        giveVerdict();
    end
endmodule : cci_counter_unit_tb
